// ### hw/drc_pkg.sv
// drc_pkg: shared constants for the dram controller mode/refresh block
package drc_pkg;
  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 25;
  localparam int unsigned CLR_HOLD_NS      = 500;
  localparam int unsigned CLR_HOLD_CYC     = (CLR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_EDGES      = 16;
  // base refresh interval 13 us, each divisor step adds 125 ns up to 14.875 us
  localparam int unsigned REFRESH_MIN_NS   = 13000;
  localparam int unsigned REFRESH_STEP_NS  = 125;
  localparam int unsigned REFRESH_MIN_CYC  = REFRESH_MIN_NS / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_STEP_CYC = REFRESH_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned RCNT_W           = 10;
  localparam int unsigned HCNT_W           = 5;
  // ----------------------------------------------------------------------
  // mode word captured from the address inputs
  // ----------------------------------------------------------------------
  localparam int unsigned MODE_W           = 8;
  localparam int unsigned MODE_ROW_DELAY   = 0;  // row_delay_bit: 1 = two clocks
  localparam int unsigned MODE_PIPELINE    = 1;  // address pipelining mode
  localparam int unsigned MODE_DIV_LSB     = 2;  // refresh_divisor_bits [5:2]
  localparam int unsigned DIV_W            = 4;
  localparam logic [MODE_W-1:0] MODE_RESET = 8'h00;
endpackage : drc_pkg

// ### hw/drc_if.sv
// drc_if: pins between the dram controller and its system-bus party
`timescale 1ns/1ps
interface drc_if import drc_pkg::*; ();
  logic              mode_load_n;
  logic              refresh_disable_n;
  logic              external_refresh_n;
  logic [MODE_W-1:0] mode_addr;
  logic              extend_col_strobe0_n;
  logic              extend_col_strobe_n;
  logic              access_request_n;
  logic              scrub_refresh;
  logic              port_b_grant;
  logic              column_increment;
  logic              col_strobe_n;
  logic              row_strobe_n;
  logic              we_refresh_n;
  logic              refresh_request_n;

  modport dev (
    input  mode_load_n, refresh_disable_n, external_refresh_n, mode_addr,
    input  extend_col_strobe0_n, extend_col_strobe_n, access_request_n,
    input  scrub_refresh, port_b_grant, column_increment,
    output col_strobe_n, row_strobe_n, we_refresh_n, refresh_request_n
  );
  modport host (
    output mode_load_n, refresh_disable_n, external_refresh_n, mode_addr,
    output extend_col_strobe0_n, extend_col_strobe_n, access_request_n,
    output scrub_refresh, port_b_grant, column_increment,
    input  col_strobe_n, row_strobe_n, we_refresh_n, refresh_request_n
  );
endinterface : drc_if

// ### hw/drc_dev.sv
// drc_dev: device end, mode capture, strobe extension, row delay, refresh clock
//
// Functional notes
// RULE1: extension keeps column strobe past request end
// RULE2: scrub refresh ignores column strobe extension
// RULE3: row strobe one/two clocks after grant change
// RULE4: refresh request on write-enable pin when enabled
// RULE5: long external refresh clears refresh counter
// RULE6: no refresh request for programmed 13-15 us
// RULE7: host resets with both inputs for 16 edges
// RULE8: host holds extend input 0 low programming; the host drives ext_feature on it, and high enables extension
// RULE9: column increment active high, tied low unused
// RULE10: mode bits captured at mode-load negation
`timescale 1ns/1ps
module drc_dev import drc_pkg::*; (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // pins to the system party
  drc_if.dev        pins,
  // precharge status from the row timing logic
  input  wire logic precharge_done,
  // status
  output logic      programmed,
  output logic      ext_enable,
  output logic      counter_cleared
);
  // ----------------------------------------------------------------------
  // hardware reset and mode capture
  // ----------------------------------------------------------------------
  logic [HCNT_W-1:0] hw_rst_cnt;
  logic              hw_reset;
  logic              ml_d;
  logic [MODE_W-1:0] mode;
  logic [MODE_W-1:0] addr_d;

  // hardware reset: both inputs asserted for sixteen edges
  always_ff @(posedge clk) begin
    if (!resetn || pins.mode_load_n || pins.refresh_disable_n) begin
      hw_rst_cnt <= '0;
      hw_reset   <= 1'b0;
    end else if (hw_rst_cnt == HCNT_W'(RESET_EDGES - 1)) begin
      hw_reset   <= 1'b1;                                   // RULE7
    end else begin
      hw_rst_cnt <= hw_rst_cnt + 1'b1;
    end
  end

  // address is sampled one edge early so the value before the rising ml is kept
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ml_d       <= 1'b1;
      addr_d     <= MODE_RESET;
      mode       <= MODE_RESET;
      ext_enable <= 1'b0;
      programmed <= 1'b0;
    end else begin
      ml_d   <= pins.mode_load_n;
      addr_d <= pins.mode_addr;
      // a hardware reset forgets the old mode so no stale feature stays on
      if (hw_reset) begin
        programmed <= 1'b0;
        mode       <= MODE_RESET;                           // RULE7
        ext_enable <= 1'b0;
      end else if (!ml_d && pins.mode_load_n) begin
        mode       <= addr_d;                               // RULE10
        ext_enable <= pins.extend_col_strobe0_n;            // RULE1 RULE8
        programmed <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // column strobe with extension
  // ----------------------------------------------------------------------
  // scrubbing cycles force the column strobe off, over both request and extension
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pins.col_strobe_n <= 1'b1;
    end else if (pins.scrub_refresh) begin
      pins.col_strobe_n <= 1'b1;                            // RULE2
    end else if (!pins.access_request_n) begin
      pins.col_strobe_n <= 1'b0;
    end else if (ext_enable && !pins.col_strobe_n && !pins.extend_col_strobe_n) begin
      pins.col_strobe_n <= 1'b0;                            // RULE1
    end else begin
      pins.col_strobe_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // row strobe after grant change
  // ----------------------------------------------------------------------
  logic       grant_d;
  logic [1:0] row_pipe;
  logic       grant_edge;
  assign grant_edge = grant_d ^ pins.port_b_grant;

  // a one-cycle delay pipe gives the second clock when row_delay_bit is set
  always_ff @(posedge clk) begin
    if (!resetn) begin
      grant_d           <= 1'b0;
      row_pipe          <= 2'b00;
      pins.row_strobe_n <= 1'b1;
    end else begin
      grant_d  <= pins.port_b_grant;
      row_pipe <= {row_pipe[0], grant_edge && precharge_done};
      if (mode[MODE_ROW_DELAY] ? row_pipe[0] : (grant_edge && precharge_done)) begin
        pins.row_strobe_n <= 1'b0;                          // RULE3
      end else if (pins.access_request_n) begin
        pins.row_strobe_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // refresh request clock
  // ----------------------------------------------------------------------
  logic [HCNT_W-1:0] clr_cnt;
  logic              clr_pulse;
  logic [RCNT_W-1:0] ref_cnt;
  logic [RCNT_W-1:0] ref_limit;

  assign ref_limit = RCNT_W'(REFRESH_MIN_CYC
                   + REFRESH_STEP_CYC * mode[MODE_DIV_LSB +: DIV_W]);

  // clear request counted while disable is high and external refresh low
  always_ff @(posedge clk) begin
    if (!resetn || !pins.refresh_disable_n || pins.external_refresh_n) begin
      clr_cnt   <= '0;
      clr_pulse <= 1'b0;
    end else if (clr_cnt == HCNT_W'(CLR_HOLD_CYC - 1)) begin
      clr_pulse <= 1'b1;                                    // RULE5
    end else begin
      clr_cnt   <= clr_cnt + 1'b1;
    end
  end

  // the counter restarts on every clear, so no request can come early
  always_ff @(posedge clk) begin
    if (!resetn || hw_reset || clr_pulse) begin
      ref_cnt                <= '0;
      pins.refresh_request_n <= 1'b1;
      counter_cleared        <= resetn && clr_pulse;
    end else begin
      counter_cleared <= 1'b0;
      if (ref_cnt >= ref_limit) begin
        ref_cnt                <= '0;
        pins.refresh_request_n <= 1'b0;                     // RULE6
      end else begin
        ref_cnt                <= ref_cnt + 1'b1;
        pins.refresh_request_n <= 1'b1;
      end
    end
  end

  // write-enable pin carries the refresh request when enabled
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pins.we_refresh_n <= 1'b1;
    end else if (ext_enable || mode[MODE_PIPELINE]) begin
      pins.we_refresh_n <= pins.refresh_request_n;          // RULE4
    end else begin
      pins.we_refresh_n <= 1'b1;
    end
  end
endmodule : drc_dev

// ### hw/drc_host.sv
// drc_host: system party driving reset, programming and refresh clear
`timescale 1ns/1ps
module drc_host import drc_pkg::*; (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // user commands
  input  wire logic              start,
  input  wire logic [MODE_W-1:0] mode_word,
  input  wire logic              ext_feature,
  input  wire logic              clear_refresh,
  input  wire logic              req_n,
  input  wire logic              ext_n,
  input  wire logic              grant,
  input  wire logic              scrub,
  // status
  output logic                   busy,
  output logic                   refresh_seen,
  // pins to the device
  drc_if.host                    pins
);
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_RESET = 5'b00010,
    S_LOAD  = 5'b00100,
    S_CLEAR = 5'b01000,
    S_DONE  = 5'b10000
  } drc_state_t;
  drc_state_t        state;
  logic [HCNT_W-1:0] cnt;

  // ----------------------------------------------------------------------
  // sequencer: reset, then load, then optional clears
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state                   <= S_IDLE;
      cnt                     <= '0;
      busy                    <= 1'b0;
      pins.mode_load_n        <= 1'b1;
      pins.refresh_disable_n  <= 1'b1;
      pins.external_refresh_n <= 1'b1;
      pins.mode_addr          <= MODE_RESET;
      pins.extend_col_strobe0_n <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (start) begin
            state                  <= S_RESET;
            busy                   <= 1'b1;
            cnt                    <= '0;
            pins.mode_load_n       <= 1'b0;
            pins.refresh_disable_n <= 1'b0;
          end
        end
        S_RESET: begin
          cnt <= cnt + 1'b1;
          if (cnt == HCNT_W'(RESET_EDGES + 1)) begin          // RULE7
            state                  <= S_LOAD;
            cnt                    <= '0;
            pins.refresh_disable_n <= 1'b1;
            pins.mode_addr         <= mode_word;
            pins.extend_col_strobe0_n <= ext_feature;       // RULE8
          end
        end
        S_LOAD: begin
          cnt <= cnt + 1'b1;
          if (cnt == HCNT_W'(2)) begin
            pins.mode_load_n <= 1'b1;                       // RULE10
          end
          if (cnt == HCNT_W'(4)) begin
            state <= S_DONE;
            busy  <= 1'b0;
          end
        end
        S_CLEAR: begin
          cnt <= cnt + 1'b1;
          if (cnt == HCNT_W'(CLR_HOLD_CYC + 1)) begin         // RULE5
            state                   <= S_DONE;
            busy                    <= 1'b0;
            pins.external_refresh_n <= 1'b1;
          end
        end
        S_DONE: begin
          if (start) begin
            state                  <= S_RESET;
            busy                   <= 1'b1;
            cnt                    <= '0;
            pins.mode_load_n       <= 1'b0;
            pins.refresh_disable_n <= 1'b0;
          end else if (clear_refresh) begin
            state                   <= S_CLEAR;
            busy                    <= 1'b1;
            cnt                     <= '0;
            pins.external_refresh_n <= 1'b0;
          end
        end
      endcase
    end
  end

  // access-side pins registered from the user; column increment held low
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pins.access_request_n    <= 1'b1;
      pins.extend_col_strobe_n <= 1'b1;
      pins.port_b_grant        <= 1'b0;
      pins.scrub_refresh       <= 1'b0;
      pins.column_increment    <= 1'b0;                     // RULE9
      refresh_seen             <= 1'b0;
    end else begin
      pins.access_request_n    <= req_n;
      pins.extend_col_strobe_n <= ext_n;
      pins.port_b_grant        <= grant;
      pins.scrub_refresh       <= scrub;
      pins.column_increment    <= 1'b0;
      refresh_seen             <= !pins.refresh_request_n;
    end
  end
endmodule : drc_host

// ### dv/drc_monitor.sv
// drc_monitor: concurrent checks on the pins between the two controller ends
`timescale 1ns/1ps
module drc_monitor import drc_pkg::*; (
  // clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // host to device
  input wire logic              mode_load_n,
  input wire logic              refresh_disable_n,
  input wire logic              external_refresh_n,
  input wire logic [MODE_W-1:0] mode_addr,
  input wire logic              extend_col_strobe0_n,
  input wire logic              extend_col_strobe_n,
  input wire logic              access_request_n,
  input wire logic              scrub_refresh,
  input wire logic              port_b_grant,
  input wire logic              column_increment,
  // device to host
  input wire logic              col_strobe_n,
  input wire logic              row_strobe_n,
  input wire logic              we_refresh_n,
  input wire logic              refresh_request_n,
  // bench side
  input wire logic              precharge_done
);
  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  localparam int MIN_GAP = REFRESH_MIN_CYC - 1;
  logic              ml_q, extend_col_strobe0_n_q, ext_en;
  logic [MODE_W-1:0] addr_q, mode;
  logic [9:0]        clr_run, quiet;
  logic [4:0]        hw_cnt;
  wire               hw_rst = !mode_load_n && !refresh_disable_n;
  // mode as the device should hold it; a reset only counts after sixteen edges
  always_ff @(posedge clk) begin
    ml_q    <= mode_load_n;
    addr_q  <= mode_addr;
    extend_col_strobe0_n_q <= extend_col_strobe0_n;
    if (!resetn || hw_cnt >= RESET_EDGES) begin
      mode   <= MODE_RESET;
      ext_en <= 1'b0;
    end else if (mode_load_n && !ml_q) begin
      mode   <= addr_q;
      ext_en <= extend_col_strobe0_n_q;
    end
  end
  // clear-request run length and quiet time since clear or request
  always_ff @(posedge clk) begin
    if (!resetn || !refresh_disable_n || external_refresh_n) clr_run <= '0;
    else if (clr_run != 10'h3ff) clr_run <= clr_run + 10'h001;
    if (!resetn || hw_cnt >= RESET_EDGES || clr_run >= CLR_HOLD_CYC || !refresh_request_n)
      quiet <= '0;
    else if (quiet != 10'h3ff) quiet <= quiet + 10'h001;
  end
  // length of the hardware reset run
  always_ff @(posedge clk) begin
    if (!resetn || !hw_rst) hw_cnt <= '0;
    else if (hw_cnt != 5'h1f) hw_cnt <= hw_cnt + 5'h01;
  end
  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  cas_follow_a: assert property (
    !access_request_n && !scrub_refresh |=> !col_strobe_n) else $error("strobe missed request");
  cas_extend_a: assert property (
    ext_en && access_request_n && !extend_col_strobe_n && !col_strobe_n && !scrub_refresh
    |=> !col_strobe_n) else $error("extension dropped early");
  cas_release_a: assert property (
    access_request_n && (!ext_en || extend_col_strobe_n || scrub_refresh) |=> col_strobe_n)
    else $error("column strobe held too long");
  row_one_a: assert property (
    $changed(port_b_grant) && !mode[MODE_ROW_DELAY] && row_strobe_n && !access_request_n
    && precharge_done
    |=> !row_strobe_n || access_request_n) else $error("row strobe not one clock");
  row_two_a: assert property (
    $changed(port_b_grant) && mode[MODE_ROW_DELAY] && row_strobe_n && !access_request_n
    && precharge_done
    |=> row_strobe_n ##1 (!row_strobe_n || access_request_n)) else $error("row strobe not two");
  we_route_a: assert property (
    (ext_en || mode[MODE_PIPELINE]) && !refresh_request_n |=> !we_refresh_n)
    else $error("refresh not on write enable");
  we_quiet_a: assert property (
    !ext_en && !mode[MODE_PIPELINE] |=> we_refresh_n) else $error("write enable moved");
  refresh_gap_a: assert property (
    !refresh_request_n |-> quiet >= MIN_GAP) else $error("refresh request too soon");
  reset_hold_a: assert property (
    $rose(refresh_disable_n) && !mode_load_n |-> hw_cnt >= RESET_EDGES)
    else $error("hardware reset too short");
  mode_stable_a: assert property (
    $rose(mode_load_n) |-> $stable(mode_addr) && $stable(extend_col_strobe0_n))
    else $error("mode bits moved at load");
  column_increment_low_a: assert property (
    !column_increment) else $error("column increment not low");
  cover property (ext_en && access_request_n && !extend_col_strobe_n && !col_strobe_n);
  cover property ($changed(port_b_grant) && mode[MODE_ROW_DELAY]);
  cover property (!we_refresh_n);
endmodule : drc_monitor

// ### dv/drc_tb.sv
// drc_tb: self-checking bench joining host and device ends
`timescale 1ns/1ps
module drc_tb import drc_pkg::*; ;
  logic              clk, resetn, start, ext_feature, clear_refresh, req_n, ext_n, grant, scrub;
  logic              precharge_done, busy, refresh_seen, programmed, ext_enable, counter_cleared;
  logic [MODE_W-1:0] mode_word;
  int                n_errors, checks_done, cnt;
  drc_if i_drc_if ();
  drc_dev i_drc_dev (.clk(clk), .resetn(resetn), .pins(i_drc_if.dev),
    .precharge_done(precharge_done), .programmed(programmed), .ext_enable(ext_enable),
    .counter_cleared(counter_cleared));
  drc_host i_drc_host (.clk(clk), .resetn(resetn), .start(start), .mode_word(mode_word),
    .ext_feature(ext_feature), .clear_refresh(clear_refresh), .req_n(req_n), .ext_n(ext_n),
    .grant(grant), .scrub(scrub), .busy(busy), .refresh_seen(refresh_seen),
    .pins(i_drc_if.host));
  drc_monitor i_drc_monitor (.clk(clk), .resetn(resetn), .mode_load_n(i_drc_if.mode_load_n),
    .precharge_done(precharge_done),
    .refresh_disable_n(i_drc_if.refresh_disable_n), .mode_addr(i_drc_if.mode_addr),
    .external_refresh_n(i_drc_if.external_refresh_n), .port_b_grant(i_drc_if.port_b_grant),
    .extend_col_strobe0_n(i_drc_if.extend_col_strobe0_n), .scrub_refresh(i_drc_if.scrub_refresh),
    .extend_col_strobe_n(i_drc_if.extend_col_strobe_n), .col_strobe_n(i_drc_if.col_strobe_n),
    .access_request_n(i_drc_if.access_request_n), .row_strobe_n(i_drc_if.row_strobe_n),
    .column_increment(i_drc_if.column_increment), .we_refresh_n(i_drc_if.we_refresh_n),
    .refresh_request_n(i_drc_if.refresh_request_n));
  // -------------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    if (n_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  // one edge, with a hang cut short
  task automatic tick();
    @(posedge clk);
    cnt++;
    if (cnt > 1000) begin
      n_errors++;
      test_done();
    end
  endtask : tick
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask : ticks
  // hardware reset and mode load, all done by the host end
  task automatic load_mode(input logic [MODE_W-1:0] m, input logic e);
    mode_word   <= m;
    ext_feature <= e;
    start       <= 1'b1;
    ticks(1);
    start <= 1'b0;
    ticks(2);
    cnt = 0;
    while (busy !== 1'b0) tick();
    ticks(2);
    check(programmed, 1);
    check(ext_enable, e);
  endtask : load_mode
  // drop the request while the extension input is still held
  task automatic cas_run(input logic e);
    req_n <= 1'b0;
    ticks(4);
    check(i_drc_if.col_strobe_n, 0);
    req_n <= 1'b1;
    ext_n <= 1'b0;
    ticks(4);
    check(i_drc_if.col_strobe_n, !e);
    ext_n <= 1'b1;
    ticks(3);
    check(i_drc_if.col_strobe_n, 1);
  endtask : cas_run
  // grant change in mid access; one edge of the count is the host copy
  task automatic row_run(input logic r);
    load_mode({2'b00, 4'h0, 1'b0, r}, 1'b0);
    req_n <= 1'b0;
    ticks(3);
    grant <= !grant;
    cnt = 0;
    do tick(); while (i_drc_if.row_strobe_n !== 1'b0);
    check(cnt, 3 + r);
    req_n <= 1'b1;
    ticks(3);
  endtask : row_run
  // clear the refresh clock, then time the next request
  task automatic rfr_run(input logic [3:0] d, input logic p, input logic e);
    int lo;
    bit clr_seen;
    clr_seen = 1'b0;
    lo = REFRESH_MIN_CYC + int'(d) * REFRESH_STEP_CYC;
    load_mode({2'b00, d, p, 1'b0}, e);
    clear_refresh <= 1'b1;
    ticks(1);
    clear_refresh <= 1'b0;
    cnt = 0;
    while (i_drc_if.refresh_request_n !== 1'b0) begin
      tick();
      if (counter_cleared === 1'b1) clr_seen = 1'b1;
    end
    check(clr_seen, 1);
    check(cnt >= lo, 1);
    check(cnt <= lo + 40, 1);
    ticks(1);
    check(i_drc_if.we_refresh_n, !(p || e));
    check(refresh_seen, 1);
  endtask : rfr_run
  // -------------------------------------------------------------------
  // clock and main sequence
  // -------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // precharge starts done and drops only for the early grant check; the monitor sees it too
  initial begin
    {resetn, start, ext_feature, clear_refresh, grant, scrub} = '0;
    {req_n, ext_n, precharge_done} = '1;
    mode_word   = 8'h00;
    n_errors    = 0;
    checks_done = 0;
    ticks(20);
    resetn <= 1'b1;
    ticks(2);
    check(i_drc_if.col_strobe_n, 1);
    row_run(1'b0);
    row_run(1'b1);
    // grant change before precharge ends must not start the row strobe
    precharge_done <= 1'b0;
    req_n          <= 1'b0;
    grant          <= !grant;
    ticks(6);
    check(i_drc_if.row_strobe_n, 1);
    precharge_done <= 1'b1;
    req_n          <= 1'b1;
    ticks(3);
    load_mode(8'h00, 1'b1);
    cas_run(1'b1);
    // scrubbing cycle forces the column strobe off even during a request
    req_n <= 1'b0;
    ticks(4);
    scrub <= 1'b1;
    ticks(3);
    check(i_drc_if.col_strobe_n, 1);
    scrub <= 1'b0;
    req_n <= 1'b1;
    ticks(3);
    load_mode(8'h00, 1'b0);
    cas_run(1'b0);
    rfr_run(4'h0, 1'b0, 1'b0);
    rfr_run(4'hf, 1'b1, 1'b0);
    rfr_run(4'h7, 1'b0, 1'b1);
    test_done();
  end
endmodule : drc_tb
